// [hw/ext_event_detect.sv]
// Edge and level detector for one external interrupt line.
// Assumes a level already synchronised to pclk.
`timescale 1ns/1ns
module ext_event_detect #(
  parameter bit HIGH_OPT = 1'b0
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Line carrier.
  ext_sense_if.det s
);
  // ****************************************
  // Edge detection
  // ****************************************
  logic prev; // Level seen on the last edge.

  // Keeps the previous level for edge detection.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev <= 1'b1;
    end else begin
      prev <= s.level;
    end
  end

  // Decodes the selected sensitivity into a hit.
  always_comb begin
    case (irq_ctrl_pkg::sense_t'(s.code))
      irq_ctrl_pkg::SENSE_RISE: s.hit = s.level & ~prev;
      irq_ctrl_pkg::SENSE_FALL: s.hit = ~s.level & prev;
      irq_ctrl_pkg::SENSE_BOTH: s.hit = s.level ^ prev;
      default: begin
        // Level mode: high level only where offered.
        if (HIGH_OPT && s.pol) begin
          s.hit = s.level;
        end else begin
          s.hit = ~s.level;
        end
      end
    endcase
  end
endmodule

// [hw/ext_sense_if.sv]
// Carrier between the controller and one external line detector.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface ext_sense_if;
  logic level; // Filtered pin level.
  logic [1:0] code; // Sensitivity field of the line.
  logic pol; // Polarity bit steering the level mode.
  logic hit; // Event seen this cycle.
  modport det (input level, code, pol, output hit);
  modport ctl (output level, code, pol, input hit);
endinterface

// [hw/irq_ctrl_params.svh]
// Constants of the vectored interrupt controller: offsets, fields,
// reset values, vectors and timing counts.
// Assumes inclusion by bare name from any design file.
`ifndef IRQ_CTRL_PARAMS_SVH
`define IRQ_CTRL_PARAMS_SVH
// Register byte offsets on the APB.
`define REG_EXT_CTRL 12'h000
`define REG_SYS_STAT 12'h004
`define REG_PENDING 12'h008
// Field positions of the status register.
`define STAT_FLAG 0
`define STAT_IRQ_EN 1
`define STAT_PEND 2
// Field positions of the external control register.
`define CTRL_POL_FIRST 8
`define CTRL_POL_SECOND 9
// Reset values.
`define EXT_CTRL_RESET 10'h000
`define SYNC_RESET 5'h0f
// Vector addresses, even byte of each pair.
`define VEC_TIME_BASE 16'hfff8
`define VEC_EXT0 16'hfff6
`define VEC_EXT1 16'hfff4
`define VEC_EXT2 16'hfff2
`define VEC_EXT3 16'hfff0
`define VEC_TIMER_A 16'hffea
`define VEC_TIMER_B 16'hffe8
`define VEC_SUPPLY 16'hffe4
// Source positions in priority order, highest first.
`define SRC_TIME_BASE 3'h0
`define SRC_TIMER_A 3'h5
`define SRC_TIMER_B 3'h6
`define SRC_SUPPLY 3'h7
// Reset delays in CPU cycles.
`define DELAY_SHORT 13'h0100
`define DELAY_LONG 13'h1000
`endif

// [hw/irq_ctrl_pkg.sv]
// Types shared by the interrupt controller files.
// Assumes nothing of its surroundings.
package irq_ctrl_pkg;
  // Sensitivity codes of one external line.
  typedef enum logic [1:0] {
    SENSE_FALL_LOW = 2'h0,
    SENSE_RISE = 2'h1,
    SENSE_FALL = 2'h2,
    SENSE_BOTH = 2'h3
  } sense_t;
  // Supply-warning start-up states.
  typedef enum logic [1:0] {
    WARN_HOLD = 2'h1,
    WARN_RUN = 2'h2
  } warn_state_t;
endpackage

// [hw/vectored_irq.sv]
// Vectored interrupt controller with external sense and supply warning.
// Assumes an APB master on pclk and a CPU that pulses vec_fetch.
`timescale 1ns/1ns
`include "irq_ctrl_params.svh"
module vectored_irq (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt sources.
  input wire logic time_base_irq,
  input wire logic timer_a_irq,
  input wire logic timer_b_irq,
  input wire logic [3:0] ext_pin,
  input wire logic supply_warning_detector,
  // Options and power modes.
  input wire logic low_voltage_reset_detector,
  input wire logic long_reset_delay,
  input wire logic flash_variant,
  input wire logic halt_mode,
  input wire logic active_halt_mode,
  // CPU vector port.
  input wire logic vec_fetch,
  output logic irq_req,
  output logic [15:0] irq_vector,
  output logic irq_wake
);
  // ****************************************
  // Declarations
  // ****************************************
  logic [4:0] sync1, sync2, sync3; // Pin synchroniser stages.
  logic [4:0] filt; // Levels accepted once stages two and three agree.
  logic [9:0] ext_ctrl; // Sensitivity fields and polarity bits.
  logic [3:0] hits; // Detector outputs.
  logic [3:0] ext_pend; // External request latches, readable in the pending register.
  logic warn_en; // Warning interrupt enable.
  logic warn_pend; // Warning request latch.
  logic warn_prev; // Flag value at the last edge.
  logic warn_flag; // Live warning flag.
  logic [12:0] warn_cnt; // Reset delay counter.
  irq_ctrl_pkg::warn_state_t warn_state; // Start-up state.
  logic [7:0] pend; // All requests in priority order.
  logic [2:0] sel; // Winning source.
  logic [2:0] irq_src; // Source now presented.
  logic apb_wr; // Write takes effect this edge.
  logic ctrl_wr, stat_wr, ctrl_change, warn_en_rise, warn_toggle;
  logic [3:0] fetch_ext; // Fetch aimed at an external latch.
  logic [12:0] delay_max; // Selected reset delay.
  default disable iff (!presetn); // Assertions rest while in reset.

  // ****************************************
  // Pin synchronisation
  // ****************************************
  // Three stages; a change counts when stages two and three agree.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= `SYNC_RESET;
      sync2 <= `SYNC_RESET;
      sync3 <= `SYNC_RESET;
      filt <= `SYNC_RESET;
    end else begin
      sync1 <= {supply_warning_detector, ext_pin};
      sync2 <= sync1;
      sync3 <= sync2;
      filt <= (sync2 & sync3) | (filt & (sync2 | sync3));
    end
  end

  // ****************************************
  // APB decoding
  // ****************************************
  assign apb_wr = psel & penable & pready & pwrite;
  assign ctrl_wr = apb_wr && (paddr == `REG_EXT_CTRL);
  assign stat_wr = apb_wr && (paddr == `REG_SYS_STAT);
  assign ctrl_change = ctrl_wr && (pwdata[9:0] != ext_ctrl);
  assign warn_en_rise = stat_wr && pwdata[`STAT_IRQ_EN] && !warn_en;

  // Ready rises for one cycle in each access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel & ~penable;
    end
  end

  // Read data and error are captured in the setup cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= 1'b0;
      if (paddr == `REG_EXT_CTRL) begin
        prdata <= {22'h0, ext_ctrl};
      end else if (paddr == `REG_SYS_STAT) begin
        // Flag reads live and is never written.
        prdata <= {29'h0, warn_pend, warn_en, warn_flag};
      end else if (paddr == `REG_PENDING) begin
        prdata <= {7'h0, irq_req, pend, irq_vector};
      end else begin
        // Unmapped address answers zero with an error.
        prdata <= 32'h0;
        pslverr <= 1'b1;
      end
    end
  end

  // Control register; software masks the CPU first.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_ctrl <= `EXT_CTRL_RESET;
    end else if (ctrl_wr) begin
      ext_ctrl <= pwdata[9:0];
    end
  end

  // Warning enable bit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warn_en <= 1'b0;
    end else if (stat_wr) begin
      warn_en <= pwdata[`STAT_IRQ_EN];
    end
  end

  // ****************************************
  // External lines
  // ****************************************
  ext_sense_if sense [3:0] ();

  // One detector per line; each sees its own field.
  for (genvar g = 0; g < 4; g++) begin : gen_line
    assign sense[g].level = filt[g];
    assign sense[g].code = ext_ctrl[2*g +: 2];
    assign sense[g].pol = (g == 0) ? ext_ctrl[`CTRL_POL_FIRST] :
                          ext_ctrl[`CTRL_POL_SECOND];
    assign hits[g] = sense[g].hit;
    ext_event_detect #(
      .HIGH_OPT((g == 0) || (g == 2))
    ) u_det (
      .pclk(pclk),
      .presetn(presetn),
      .s(sense[g])
    );
  end

  // Fetch clears the presented external latch.
  always_comb begin
    fetch_ext = 4'h0;
    if (vec_fetch && irq_req && irq_src >= 3'h1 && irq_src <= 3'h4) begin
      fetch_ext[irq_src[1:0] - 2'h1] = 1'b1;
    end
  end

  // Latches: a changed control value clears them first.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_pend <= 4'h0;
    end else if (ctrl_change) begin
      ext_pend <= 4'h0;
    end else begin
      ext_pend <= (ext_pend & ~fetch_ext) | hits;
    end
  end

  // ****************************************
  // Supply warning
  // ****************************************
  assign warn_flag = filt[4] & low_voltage_reset_detector;
  assign delay_max = long_reset_delay ? `DELAY_LONG : `DELAY_SHORT;
  assign warn_toggle = (warn_state == irq_ctrl_pkg::WARN_RUN) &&
                       (warn_flag != warn_prev);

  // Holds off toggles for the reset delay after reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warn_state <= irq_ctrl_pkg::WARN_HOLD;
      warn_cnt <= 13'h0;
    end else begin
      case (warn_state)
        irq_ctrl_pkg::WARN_HOLD: begin
          warn_cnt <= warn_cnt + 13'h1;
          if (warn_cnt >= delay_max - 13'h1) begin
            warn_state <= irq_ctrl_pkg::WARN_RUN;
          end
        end
        default: warn_state <= irq_ctrl_pkg::WARN_RUN;
      endcase
    end
  end

  // Remembers the flag for toggle detection.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warn_prev <= 1'b0;
    end else begin
      warn_prev <= warn_flag;
    end
  end

  // Request on toggle or on enabling; set wins over fetch.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warn_pend <= 1'b0;
    end else if (!low_voltage_reset_detector) begin
      warn_pend <= 1'b0;
    end else if (warn_en_rise || (warn_en && warn_toggle)) begin
      warn_pend <= 1'b1;
    end else if (vec_fetch && irq_req && irq_src == `SRC_SUPPLY) begin
      warn_pend <= 1'b0;
    end
  end

  // ****************************************
  // Priority and vectors
  // ****************************************
  assign pend = {warn_pend, timer_b_irq, timer_a_irq, ext_pend,
                 time_base_irq};

  // Lowest set position wins.
  always_comb begin
    sel = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (pend[i]) begin
        sel = 3'(i);
      end
    end
  end

  // Presents the winner and its vector.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req <= 1'b0;
      irq_src <= 3'h0;
      irq_vector <= `VEC_TIME_BASE;
    end else begin
      irq_req <= |pend;
      irq_src <= sel;
      case (sel)
        3'h0: irq_vector <= `VEC_TIME_BASE;
        3'h1: irq_vector <= `VEC_EXT0;
        3'h2: irq_vector <= `VEC_EXT1;
        3'h3: irq_vector <= `VEC_EXT2;
        3'h4: irq_vector <= `VEC_EXT3;
        3'h5: irq_vector <= `VEC_TIMER_A;
        3'h6: irq_vector <= `VEC_TIMER_B;
        default: irq_vector <= `VEC_SUPPLY;
      endcase
    end
  end

  // Wake from halt or active-halt; timers and warning never wake.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_wake <= 1'b0;
    end else if (halt_mode) begin
      irq_wake <= time_base_irq | (|ext_pend);
    end else if (active_halt_mode) begin
      irq_wake <= time_base_irq | (~flash_variant & (|ext_pend));
    end else begin
      irq_wake <= 1'b0;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  tb_vector_a: assert property (@(posedge pclk)
    time_base_irq |=> irq_req && irq_vector == `VEC_TIME_BASE)
    else $error("time base not presented first");
  ext_vector_a: assert property (@(posedge pclk)
    pend == 8'h10 |=> irq_vector == `VEC_EXT3)
    else $error("fourth line vector wrong");
  timer_wake_a: assert property (@(posedge pclk)
    (pend[4:0] == 5'h0 && !ctrl_change) |=> !irq_wake)
    else $error("timer or warning woke the device");
  supply_last_a: assert property (@(posedge pclk)
    pend == 8'h80 |=> irq_src == `SRC_SUPPLY && irq_vector == `VEC_SUPPLY)
    else $error("warning vector wrong");
  flash_halt_a: assert property (@(posedge pclk)
    (active_halt_mode && !halt_mode && flash_variant && !time_base_irq)
    |=> !irq_wake)
    else $error("active-halt woken by other source");
  ctrl_clear_a: assert property (@(posedge pclk)
    ctrl_change |=> ext_pend == 4'h0)
    else $error("pending lines not cleared");
  warn_off_a: assert property (@(posedge pclk)
    !low_voltage_reset_detector |=> !warn_pend)
    else $error("warning active without detector");
  warn_hold_a: assert property (@(posedge pclk)
    (warn_state == irq_ctrl_pkg::WARN_HOLD && !warn_en_rise && !warn_pend)
    |=> !warn_pend)
    else $error("warning raised during reset delay");
  warn_enable_a: assert property (@(posedge pclk)
    (warn_en_rise && low_voltage_reset_detector) |=> warn_pend)
    else $error("enabling gave no warning request");
endmodule

// [tb/cpu_vector_model.sv]
// CPU-side model that fetches the presented interrupt vector.
// Assumes the controller's vector port on the same pclk.
`timescale 1ns/1ns
module cpu_vector_model (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Vector port of the controller.
  input wire logic irq_req,
  input wire logic [15:0] irq_vector,
  output logic vec_fetch,
  // Bench control and record.
  input wire logic auto_ack,
  output logic [15:0] last_vector
);
  logic [1:0] gap; // Cycles left before another fetch is allowed.
  // One-cycle fetch pulse, then a gap because the vector lags a cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vec_fetch <= 1'b0;
      gap <= 2'h0;
    end else if (auto_ack && irq_req && gap == 2'h0) begin
      vec_fetch <= 1'b1;
      gap <= 2'h3;
    end else begin
      vec_fetch <= 1'b0;
      if (gap != 2'h0) begin
        gap <= gap - 2'h1;
      end
    end
  end

  // The vector is taken at the edge where the pulse is seen, as the
  // controller clears the source it presents at that same edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_vector <= 16'h0000;
    end else if (vec_fetch) begin
      last_vector <= irq_vector;
    end
  end
endmodule

// [tb/vectored_irq_with_ext_sense_test.sv]
// Self-checking bench of the vectored interrupt controller.
// Assumes the design files and the CPU model are compiled first.
`timescale 1ns/1ns
module vectored_irq_with_ext_sense_test;
  logic pclk = 1'b0, presetn = 1'b0; // Clock and reset.
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB controls.
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err;
  logic tb_irq = 1'b0, ta_irq = 1'b0, tbb_irq = 1'b0, sw_det = 1'b0;
  logic [3:0] ext_pin = 4'hf; // Pins idle high.
  logic det_on = 1'b1, flash = 1'b0, halt = 1'b0, ahalt = 1'b0;
  logic long_delay = 1'b0; // Option: long reset delay.
  logic vec_fetch, irq_req, irq_wake, ack = 1'b0;
  logic [15:0] irq_vector, last_vec;
  int failures = 0, n_checks = 0;
  logic [9:0] r;
  // Clock of 100 ns period.
  always #50 pclk = ~pclk;
  vectored_irq i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .time_base_irq(tb_irq), .timer_a_irq(ta_irq), .timer_b_irq(tbb_irq),
    .ext_pin(ext_pin), .supply_warning_detector(sw_det),
    .low_voltage_reset_detector(det_on), .long_reset_delay(long_delay),
    .flash_variant(flash), .halt_mode(halt), .active_halt_mode(ahalt),
    .vec_fetch(vec_fetch), .irq_req(irq_req), .irq_vector(irq_vector),
    .irq_wake(irq_wake));
  cpu_vector_model i_cpu (.pclk(pclk), .presetn(presetn),
    .irq_req(irq_req), .irq_vector(irq_vector), .vec_fetch(vec_fetch),
    .auto_ack(ack), .last_vector(last_vec));
  // Expected vector of an external line, descending pairs.
  function automatic logic [15:0] ext_vec(input int i);
    return 16'hfff6 - 16'(2 * i);
  endfunction
  // Reports the verdict and ends the run.
  task automatic stop_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Compares one result and counts it.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Lets n edges pass; outputs are then read as settled before the edge.
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // One APB transfer; the answer is taken at the edge pready is high.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      failures++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Lets the CPU model fetch for a while.
  task automatic fetch();
    ack <= 1'b1;
    settle(8);
    ack <= 1'b0;
    settle(2);
  endtask
  // **************************************************************
  // Main sequence.
  // **************************************************************
  initial begin
    void'($urandom(91));
    settle(3);
    presetn <= 1'b1;
    settle(1);
    chk(irq_vector, 16'hfff8);
    chk(irq_req, 1'b0);
    r = 10'($urandom);
    apb(1'b1, 12'h000, {22'h0, r});
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, {22'h0, r});
    apb(1'b0, 12'hffc, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, 12'h000, 32'h0000_00aa);
    apb(1'b1, 12'h004, 32'h3);
    settle(3);
    chk(irq_vector, 16'hffe4);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd[0], 1'b0);
    fetch();
    chk(last_vec, 16'hffe4);
    sw_det <= 1'b1;
    settle(8);
    chk(irq_req, 1'b0);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd[0], 1'b1);
    halt <= 1'b1;
    tb_irq <= 1'b1;
    settle(3);
    chk(irq_vector, 16'hfff8);
    chk(irq_wake, 1'b1);
    tb_irq <= 1'b0;
    ta_irq <= 1'b1;
    tbb_irq <= 1'b1;
    settle(3);
    chk(irq_vector, 16'hffea);
    chk(irq_wake, 1'b0);
    ta_irq <= 1'b0;
    settle(3);
    chk(irq_vector, 16'hffe8);
    tbb_irq <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      ext_pin[i] <= 1'b0;
      settle(8);
      chk(irq_vector, ext_vec(i));
      chk(irq_wake, 1'b1);
      fetch();
      chk(irq_req, 1'b0);
      ext_pin[i] <= 1'b1;
      settle(8);
      chk(irq_req, 1'b0);
    end
    apb(1'b1, 12'h000, 32'h1);
    ext_pin[0] <= 1'b0;
    settle(8);
    chk(irq_req, 1'b0);
    ext_pin[0] <= 1'b1;
    settle(8);
    chk(irq_vector, 16'hfff6);
    apb(1'b1, 12'h000, 32'h3);
    settle(2);
    chk(irq_req, 1'b0);
    ext_pin[0] <= 1'b0;
    settle(8);
    chk(irq_req, 1'b1);
    apb(1'b1, 12'h000, 32'h3);
    settle(2);
    chk(irq_req, 1'b1);
    apb(1'b1, 12'h000, 32'h0);
    fetch();
    chk(irq_req, 1'b1);
    ext_pin[0] <= 1'b1;
    fetch();
    chk(irq_req, 1'b0);
    apb(1'b1, 12'h000, 32'h300);
    settle(4);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd[23:16], 8'h0a);
    apb(1'b1, 12'h000, 32'haa);
    settle(2);
    chk(irq_req, 1'b0);
    halt <= 1'b0;
    flash <= 1'b1;
    ahalt <= 1'b1;
    ext_pin[0] <= 1'b0;
    settle(8);
    chk(irq_wake, 1'b0);
    tb_irq <= 1'b1;
    settle(3);
    chk(irq_wake, 1'b1);
    tb_irq <= 1'b0;
    fetch();
    ext_pin[0] <= 1'b1;
    flash <= 1'b0;
    ahalt <= 1'b0;
    halt <= 1'b1;
    settle(256);
    sw_det <= 1'b0;
    settle(8);
    chk(irq_vector, 16'hffe4);
    chk(irq_wake, 1'b0);
    ta_irq <= 1'b1;
    settle(3);
    chk(irq_vector, 16'hffea);
    ta_irq <= 1'b0;
    fetch();
    sw_det <= 1'b1;
    settle(8);
    chk(irq_vector, 16'hffe4);
    fetch();
    det_on <= 1'b0;
    settle(2);
    sw_det <= 1'b0;
    settle(8);
    chk(irq_req, 1'b0);
    // Second reset with the long delay: a toggle after 256 stays quiet.
    det_on <= 1'b1;
    long_delay <= 1'b1;
    presetn <= 1'b0;
    settle(3);
    presetn <= 1'b1;
    settle(2);
    chk(irq_req, 1'b0);
    apb(1'b1, 12'h004, 32'h2);
    fetch();
    chk(last_vec, 16'hffe4);
    settle(300);
    sw_det <= 1'b1;
    settle(8);
    chk(irq_req, 1'b0);
    settle(3800);
    sw_det <= 1'b0;
    settle(8);
    chk(irq_vector, 16'hffe4);
    stop_test();
  end
endmodule
